// ---- hdl/wlh_params.svh ----
`ifndef WLH_PARAMS_SVH
`define WLH_PARAMS_SVH
// Supervisory timing, 2 MHz instruction-base clock derived from 200 MHz
`define WLH_CLK_SYS_HZ       200000000
`define WLH_BASE_CLK_HZ      2000000
`define WLH_BASE_DIV         (`WLH_CLK_SYS_HZ / `WLH_BASE_CLK_HZ)
`define WLH_TERM_TIME_MS     1000
`define WLH_TERM_TICKS       ((`WLH_BASE_CLK_HZ / 1000) * `WLH_TERM_TIME_MS)
`define WLH_RESET_PULSE_CYC  16
`endif

// ---- hdl/wlh_pkg.sv ----
package wlh_pkg;
  typedef enum logic [1:0] {
    WLH_RUN,
    WLH_WAIT_BOUNDARY,
    WLH_HOLD
  } wlh_hold_state_type;
endpackage

// ---- hdl/wlh_sync.sv ----
`timescale 1ns/1ps
// Three-stage synchroniser; output changes once stages two and three agree
module wlh_sync (
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  input  wire logic async_i,
  output logic      level_o
);
  logic s1;
  logic s2;
  logic s3;
  wire  agree = (s2 == s3);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1      <= 1'b0;
      s2      <= 1'b0;
      s3      <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (agree) begin
        level_o <= s3;
      end
    end
  end
endmodule

// ---- hdl/wlh_top.sv ----
`timescale 1ns/1ps
// Behaviour
// - Timer terminal count of one second resets chip
// - Timer starts at reset release, never disabled
// - Low supply indication enters hold
// - Supply recovered leaves hold, execution resumes
// - Hold entry only at instruction completion
// - Ring oscillator keeps running during hold
// - All stored state frozen during hold; the watchdog timer keeps counting
// - One second derived from 2 MHz clock
`include "wlh_params.svh"
module wlh_top
  import wlh_pkg::*;
#(
  parameter int unsigned TERM_TICKS = `WLH_TERM_TICKS,
  parameter int unsigned BASE_DIV   = `WLH_BASE_DIV
) (
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  input  wire logic timer_clear_i,
  input  wire logic instr_done_i,
  input  wire logic low_supply_i,
  output logic      chip_reset_o,
  output logic      core_hold_o,
  output logic      ring_oscillator_run_o,
  output logic      state_freeze_o
);
  localparam int CW = $clog2(TERM_TICKS + 1);
  localparam int DW = $clog2(BASE_DIV + 1);
  localparam int PW = $clog2(`WLH_RESET_PULSE_CYC + 1);

  logic [DW-1:0] div_cnt;
  logic [CW-1:0] timer_cnt;
  logic [PW-1:0] pulse_cnt;
  logic          low_supply_s;
  wlh_hold_state_type state;
  wlh_hold_state_type next_state;

  wlh_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .async_i   (low_supply_i),
    .level_o   (low_supply_s)
  );

  // 2 MHz base tick from the system clock
  wire base_tick  = (div_cnt == DW'(BASE_DIV - 1));
  // A clear in the terminal cycle wins, so a timely program is never reset
  wire terminal   = (timer_cnt == CW'(TERM_TICKS - 1)) && base_tick
                    && !timer_clear_i;
  wire pulse_busy = (pulse_cnt != '0);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= base_tick ? '0 : div_cnt + DW'(1);
    end
  end

  // No enable input exists; the count only stops while the reset pulse is out
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_cnt <= '0;
    end else if (timer_clear_i || terminal || pulse_busy) begin
      timer_cnt <= '0;
    end else if (base_tick) begin
      timer_cnt <= timer_cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pulse_cnt    <= '0;
      chip_reset_o <= 1'b0;
    end else begin
      if (terminal) begin
        pulse_cnt <= PW'(`WLH_RESET_PULSE_CYC);
      end else if (pulse_busy) begin
        pulse_cnt <= pulse_cnt - PW'(1);
      end
      chip_reset_o <= terminal || (pulse_cnt > PW'(1));
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      WLH_RUN: begin
        if (low_supply_s) begin
          next_state = instr_done_i ? WLH_HOLD : WLH_WAIT_BOUNDARY;
        end
      end
      WLH_WAIT_BOUNDARY: begin
        if (!low_supply_s) begin
          next_state = WLH_RUN;
        end else if (instr_done_i) begin
          next_state = WLH_HOLD;
        end
      end
      WLH_HOLD: begin
        if (!low_supply_s) begin
          next_state = WLH_RUN;
        end
      end
      default: begin
        next_state = WLH_RUN;
      end
    endcase
  end

  wire next_hold = (next_state == WLH_HOLD);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state                 <= WLH_RUN;
      core_hold_o           <= 1'b0;
      state_freeze_o        <= 1'b0;
      ring_oscillator_run_o <= 1'b1;
    end else begin
      state                 <= next_state;
      core_hold_o           <= next_hold;
      state_freeze_o        <= next_hold;
      ring_oscillator_run_o <= 1'b1;
    end
  end
endmodule

// ---- verif/wlh_top_properties.sv ----
`timescale 1ns/1ps
module wlh_top_properties (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic timer_clear_i,
  input wire logic instr_done_i,
  input wire logic low_supply_i,
  input wire logic chip_reset_o,
  input wire logic core_hold_o,
  input wire logic ring_oscillator_run_o,
  input wire logic state_freeze_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_osc_on: assert property (ring_oscillator_run_o) else $error("osc");
  a_freeze_same: assert property (state_freeze_o == core_hold_o) else $error("frz");
  a_hold_boundary: assert property ($rose(core_hold_o) |-> $past(instr_done_i))
    else $error("bnd");
  a_hold_low: assert property ($rose(core_hold_o) |-> low_supply_i) else $error("low");
  a_hold_kept: assert property (core_hold_o && low_supply_i |=> core_hold_o)
    else $error("kept");
  a_hold_release: assert property (!low_supply_i [*8] |-> !core_hold_o)
    else $error("rel");
  a_pulse_len: assert property ($rose(chip_reset_o) |-> ##15 chip_reset_o ##1 !chip_reset_o)
    else $error("len");
  a_clear_quiet: assert property (timer_clear_i && !chip_reset_o |=> !chip_reset_o [*8])
    else $error("clr");
endmodule
bind wlh_top wlh_top_properties u_wlh_top_properties (.*);

// ---- verif/wlh_core_model.sv ----
`timescale 1ns/1ps
module wlh_core_model (
  input  wire logic clk_i,
  input  wire logic hold_i,
  input  wire logic kick_i,
  output logic      done_o,
  output logic      clear_o
);
  logic [2:0] ph = 3'h0;
  initial {done_o, clear_o} = 2'h0;
  // Stalled core neither retires nor clears
  always @(posedge clk_i) begin
    if (!hold_i) ph <= #1 ph + 3'h1;
    done_o  <= #1 !hold_i && ph[1:0] == 2'h3;
    clear_o <= #1 !hold_i && kick_i && ph == 3'h7;
  end
endmodule

// ---- verif/wlh_top_tb.sv ----
`timescale 1ns/1ps
module wlh_top_tb;
  logic clk_sys_i = 0, reset_n_i = 0, low_supply_i = 0, kick = 0;
  logic timer_clear_i, instr_done_i, chip_reset_o, core_hold_o, ring_oscillator_run_o;
  logic state_freeze_o;
  int   n_fail = 0, checks = 0, k;
  always #2.5 clk_sys_i = ~clk_sys_i;
  wlh_top #(.TERM_TICKS(20), .BASE_DIV(2)) u_wlh_top (.*);
  wlh_core_model u_wlh_core_model (.clk_i(clk_sys_i), .hold_i(core_hold_o), .kick_i(kick),
    .done_o(instr_done_i), .clear_o(timer_clear_i));
  task test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'h1) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic wt(ref logic s, input logic v, input int lim);
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge clk_sys_i);
      #1 k++;
    end
    if (s !== v) begin
      chk(1'h0, "hang");
      test_done;
    end
  endtask
  // Terminal count is 40 cycles with these parameters
  task t_dog;
    wt(chip_reset_o, 1'h1, 60);
    chk(k >= 38 && k <= 44, "first");
    wt(chip_reset_o, 1'h0, 20);
    chk(k == 16, "len");
    wt(chip_reset_o, 1'h1, 60);
    chk(k >= 38 && k <= 44, "again");
    wt(chip_reset_o, 1'h0, 20);
  endtask
  task t_kick;
    kick = 1'h1;
    repeat (100) begin
      @(posedge clk_sys_i);
      #1 chk(chip_reset_o === 1'h0, "dog");
    end
  endtask
  task t_hold;
    low_supply_i = 1'h1;
    wt(core_hold_o, 1'h1, 20);
    repeat (4) @(posedge clk_sys_i);
    #1 chk(state_freeze_o === 1'h1 && ring_oscillator_run_o === 1'h1, "frz");
    low_supply_i = 1'h0;
    wt(core_hold_o, 1'h0, 8);
    chk(state_freeze_o === 1'h0, "thaw");
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_i);
    chk(chip_reset_o === 1'h0 && ring_oscillator_run_o === 1'h1, "rst");
    #1 reset_n_i = 1'h1;
    t_dog;
    t_kick;
    t_hold;
    test_done;
  end
endmodule
